/* rtl/scpm_defines.vh */
/*
 Constants for the system clock and power-mode controller.
 Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef SCPM_DEFINES_VH
`define SCPM_DEFINES_VH

// Register byte offsets on APB
`define SCPM_OFS_MODE 12'h000
`define SCPM_OFS_CTRL 12'h004
`define SCPM_OFS_STAT 12'h008
`define SCPM_OFS_CMD 12'h00C

// Mode control register fields
`define SCPM_MODE_SRC_BIT 0
`define SCPM_MODE_IDLE_BIT 1
`define SCPM_MODE_HRDY_BIT 2
`define SCPM_MODE_LRDY_BIT 3
`define SCPM_MODE_DIV_LSB 5
`define SCPM_MODE_RESET 8'h03

// Clock and reset-flag register fields
`define SCPM_CTRL_FSYS_BIT 7
`define SCPM_CTRL_WRF_BIT 0
`define SCPM_CTRL_LRF_BIT 1
`define SCPM_CTRL_LVR_RESET_FLAG_BIT 2
`define SCPM_CTRL_RESET 8'h00
`define SCPM_CTRL_WMASK 8'h87

// Status register fields
`define SCPM_STAT_PDF_BIT 0
`define SCPM_STAT_TO_BIT 1
`define SCPM_STAT_MODE_LSB 4

// Command register bits
`define SCPM_CMD_HALT_BIT 0
`define SCPM_CMD_CLRWDT_BIT 1
`define SCPM_CMD_WAKE_BIT 2

// Operating modes
`define SCPM_M_NORMAL 2'b00
`define SCPM_M_SLEEP 2'b01
`define SCPM_M_IDLE_CLOCK_STOPPED_MODE 2'b10
`define SCPM_M_IDLE_CLOCK_RUNNING_MODE 2'b11

// Divider codes
`define SCPM_DIV_64 3'b010
`define SCPM_DIV_32 3'b011
`define SCPM_DIV_16 3'b100
`define SCPM_DIV_8 3'b101
`define SCPM_DIV_4 3'b110
`define SCPM_DIV_2 3'b111

// Oscillator settle counts: fast in pclk cycles, slow in low_rc_tick pulses
`define SCPM_HRC_SETTLE 8'h10
`define SCPM_LRC_SETTLE 8'h20

`endif

/* rtl/scpm_top.v */
/*
 System clock select and power-mode controller with APB registers.
 Assumes pclk stands for the high-speed RC clock, low_rc_tick is a one-cycle
 pulse per low-speed RC period synchronous to pclk, and all inputs are
 synchronous to pclk. Clocks leave the block as one-cycle enables.
 The enables are meant to qualify flops that run on pclk. Gated clocks are not
 used, so switching the divider or entering a low-power mode cannot cut a pulse.
 Operating modes and the clocks that they let through:
   normal       cpu on,  system on (/1 to /64), substitute on, watchdog on, time base on
   sleep        cpu off, system off,          substitute on, watchdog on, time base off
   idle, stop   cpu off, system off,          substitute on, watchdog on, time base on
   idle, run    cpu off, system on,           substitute on, watchdog on, time base on
 A halt written in a low-power mode is ignored. Only a wake command or a watchdog
 timeout returns the block to normal mode. The register bus keeps working in
 every mode, because software stands for the cpu here.
 The watchdog counter itself lives outside; this block only pulses wdt_clear.
 Its clock enable runs when either the watchdog or the voltage detector is on.
*/
// Added by the designer: the APB slave port and the placing of the registers.
// How it works
// RULE1 - system clock from fast clock or divider
// RULE2 - source bit one selects undivided clock
// RULE3 - divider codes 64 down to 2, two reserved
// RULE4 - normal mode runs cpu, ratio 1 to 64
// RULE5 - substitute and time base from slow clock
// RULE6 - halt with idle off enters sleep
// RULE7 - sleep stops system and time base clocks
// RULE8 - watchdog, detector run on slow clock
// RULE9 - idle with sysclk off enters idle_clock_stopped_mode
// RULE10 - idle with sysclk on enters idle_clock_running_mode
// RULE11 - bit 7 keeps sysclk running idle
// RULE12 - low power keeps registers and ports
// RULE13 - entry clears watchdog, counting resumes
// RULE14 - entry sets power-down, clears timeout
// RULE15 - fast ready flag set after settling
// RULE16 - slow ready flag set after settling
// RULE17 - unimplemented bits read zero
// RULE18 - power-down and timeout flag clear sources
// RULE19 - source switch without glitched pulses
`timescale 1ns/1ps
`include "scpm_defines.vh"

module scpm_top (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Slow oscillator and watchdog
    input wire low_rc_tick,
    input wire wdt_enable,
    input wire lvd_enable,
    input wire wdt_timeout,
    // Clock enables out
    output reg sysclk_en,
    output reg cpu_run,
    output reg sub_clk_en,
    output reg wdt_clk_en,
    output reg tbc_clk_en,
    output reg wdt_clear,
    output reg hold_state
);

    reg [2:0] div_sel_q;
    reg src_sel_q;
    reg idle_en_q;
    reg fsys_q;
    reg [2:0] rflags_q;
    reg pdf_q;
    reg to_q;
    reg [1:0] mode_q;
    reg [7:0] hcnt_q;
    reg [7:0] lcnt_q;
    reg hrdy_q;
    reg lrdy_q;
    reg [5:0] div_cnt_q;
    reg [2:0] div_act_q;
    reg src_act_q;

    wire wr_acc = psel && penable && pwrite;
    wire rd_acc = psel && penable && !pwrite;
    wire map_hit = (paddr == `SCPM_OFS_MODE) || (paddr == `SCPM_OFS_CTRL) ||
                   (paddr == `SCPM_OFS_STAT) || (paddr == `SCPM_OFS_CMD);
    wire wr_cmd = wr_acc && (paddr == `SCPM_OFS_CMD);
    wire halt_cmd = wr_cmd && pwdata[`SCPM_CMD_HALT_BIT] && (mode_q == `SCPM_M_NORMAL);
    wire clr_cmd = wr_cmd && pwdata[`SCPM_CMD_CLRWDT_BIT];
    wire wake_cmd = wr_cmd && pwdata[`SCPM_CMD_WAKE_BIT];

    // Divide ratio minus one for a divider code; reserved codes run as /64
    function [5:0] scpm_div_max;
        input [2:0] code;
        begin
            case (code)
                `SCPM_DIV_32: scpm_div_max = 6'h1F; // RULE3
                `SCPM_DIV_16: scpm_div_max = 6'h0F; // RULE3
                `SCPM_DIV_8: scpm_div_max = 6'h07; // RULE3
                `SCPM_DIV_4: scpm_div_max = 6'h03; // RULE3
                `SCPM_DIV_2: scpm_div_max = 6'h01; // RULE3
                default: scpm_div_max = 6'h3F; // RULE3
            endcase
        end
    endfunction

    // Mode a halt would enter
    function [1:0] scpm_halt_mode;
        input idle;
        input fsys;
        begin
            if (!idle) begin
                scpm_halt_mode = `SCPM_M_SLEEP; // RULE6
            end else if (fsys) begin
                scpm_halt_mode = `SCPM_M_IDLE_CLOCK_RUNNING_MODE; // RULE10 RULE11
            end else begin
                scpm_halt_mode = `SCPM_M_IDLE_CLOCK_STOPPED_MODE; // RULE9 RULE11
            end
        end
    endfunction

    // Which clocks a mode lets through: {cpu, system, time base}
    function [2:0] scpm_mode_clocks;
        input [1:0] mode;
        begin
            case (mode)
                `SCPM_M_NORMAL: begin
                    scpm_mode_clocks = 3'b111; // RULE4
                end
                `SCPM_M_SLEEP: begin
                    scpm_mode_clocks = 3'b000; // RULE7
                end
                `SCPM_M_IDLE_CLOCK_STOPPED_MODE: begin
                    scpm_mode_clocks = 3'b001; // RULE9
                end
                `SCPM_M_IDLE_CLOCK_RUNNING_MODE: begin
                    scpm_mode_clocks = 3'b011; // RULE10
                end
                default: begin
                    scpm_mode_clocks = 3'b000;
                end
            endcase
        end
    endfunction

    // True on the last count of a settle interval
    function scpm_settle_last;
        input [7:0] count;
        input [7:0] settle;
        begin
            scpm_settle_last = (count == settle - 8'h01);
        end
    endfunction

    wire [2:0] mode_clks = scpm_mode_clocks(mode_q);
    // Any way out of a low-power mode
    wire wake_evt = (mode_q != `SCPM_M_NORMAL) && ((wake_cmd && pready) || wdt_timeout);

    // Read views; unimplemented bits are tied to zero
    wire [7:0] mode_rd = {
        div_sel_q,
        1'b0, // RULE17
        lrdy_q,
        hrdy_q,
        idle_en_q,
        src_sel_q
    };
    wire [7:0] ctrl_rd = {
        fsys_q,
        4'h0, // RULE17
        rflags_q
    };
    wire [7:0] stat_rd = {
        2'b00,
        mode_q,
        2'b00,
        to_q,
        pdf_q
    };

    // Register view for one byte address; unmapped and write-only words read zero
    function [7:0] scpm_read_byte;
        input [11:0] addr;
        input [7:0] mode_v;
        input [7:0] ctrl_v;
        input [7:0] stat_v;
        begin
            case (addr)
                `SCPM_OFS_MODE: begin
                    scpm_read_byte = mode_v;
                end
                `SCPM_OFS_CTRL: begin
                    scpm_read_byte = ctrl_v;
                end
                `SCPM_OFS_STAT: begin
                    scpm_read_byte = stat_v;
                end
                default: begin
                    scpm_read_byte = 8'h00;
                end
            endcase
        end
    endfunction

    // APB: zero-wait slave, unmapped addresses flag an error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !map_hit;
            if (psel && !penable && !pwrite) begin
                prdata <= {24'h00_0000, scpm_read_byte(paddr, mode_rd, ctrl_rd, stat_rd)};
            end else if (psel && !penable && !map_hit) begin
                // A refused write must not show stale read data beside its error
                prdata <= 32'h0000_0000;
            end else if (rd_acc) begin
                prdata <= prdata;
            end
        end
    end

    // Software registers; write lands on the access cycle when pready is high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sel_q <= 1'b1;
            idle_en_q <= 1'b1;
            div_sel_q <= 3'b000;
            fsys_q <= 1'b0;
            rflags_q <= 3'b000;
        end else if (clk_en) begin
            if (wr_acc && pready && (paddr == `SCPM_OFS_MODE)) begin
                src_sel_q <= pwdata[`SCPM_MODE_SRC_BIT];
                idle_en_q <= pwdata[`SCPM_MODE_IDLE_BIT];
                div_sel_q <= pwdata[`SCPM_MODE_DIV_LSB+2:`SCPM_MODE_DIV_LSB];
            end
            if (wr_acc && pready && (paddr == `SCPM_OFS_CTRL)) begin
                fsys_q <= pwdata[`SCPM_CTRL_FSYS_BIT];
                rflags_q <= pwdata[2:0];
            end
        end
    end

    // Mode sequencer and status flags
    // A halt is only honoured in normal mode; the wake paths only outside it.
    // wdt_clear is a one-cycle pulse for the external watchdog counter, which
    // restarts from zero on every low-power entry and on a clear command.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `SCPM_M_NORMAL;
            pdf_q <= 1'b0; // RULE18
            to_q <= 1'b0; // RULE18
            wdt_clear <= 1'b0;
        end else if (clk_en) begin
            wdt_clear <= 1'b0;
            case (mode_q)
                `SCPM_M_NORMAL: begin
                    if (halt_cmd && pready) begin
                        mode_q <= scpm_halt_mode(idle_en_q, fsys_q);
                        wdt_clear <= 1'b1; // RULE13
                    end
                end
                `SCPM_M_SLEEP, `SCPM_M_IDLE_CLOCK_STOPPED_MODE, `SCPM_M_IDLE_CLOCK_RUNNING_MODE: begin
                    if ((wake_cmd && pready) || wdt_timeout) begin
                        mode_q <= `SCPM_M_NORMAL;
                    end
                end
                default: mode_q <= `SCPM_M_NORMAL;
            endcase
            // Timeout set wins over a same-cycle clear
            if (wdt_timeout) begin
                to_q <= 1'b1; // RULE18
            end else if ((halt_cmd || clr_cmd) && pready) begin
                to_q <= 1'b0; // RULE14 RULE18
            end
            if (halt_cmd && pready) begin
                pdf_q <= 1'b1; // RULE14
            end else if (clr_cmd && pready) begin
                pdf_q <= 1'b0; // RULE18
                wdt_clear <= 1'b1;
            end
        end
    end

    // Fast oscillator settling; the flag only rises until the next reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hcnt_q <= 8'h00;
            hrdy_q <= 1'b0;
        end else if (clk_en) begin
            if (!hrdy_q) begin
                hcnt_q <= hcnt_q + 8'h01;
                hrdy_q <= scpm_settle_last(hcnt_q, `SCPM_HRC_SETTLE); // RULE15
            end
        end
    end

    // Slow oscillator settling counts low_rc_tick pulses, not pclk cycles.
    // A wake-up restarts it, so software sees the slow clock as unsettled
    // until the same interval has passed again after every low-power stay.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lcnt_q <= 8'h00;
            lrdy_q <= 1'b0;
        end else if (clk_en) begin
            if (wake_evt) begin
                lcnt_q <= 8'h00;
                lrdy_q <= 1'b0; // RULE16
            end else if (!lrdy_q && low_rc_tick) begin
                lcnt_q <= lcnt_q + 8'h01;
                lrdy_q <= scpm_settle_last(lcnt_q, `SCPM_LRC_SETTLE); // RULE16
            end
        end
    end

    // Divider; new ratio or source taken only at the wrap, or on any cycle while undivided, so no pulse is cut.
    // The cost is latency: a change from /64 may take up to 64 cycles to show.
    // The counter keeps running in the stopped modes, so a wake-up resumes on
    // the old phase instead of producing a short first period.
    wire [5:0] div_max = scpm_div_max(div_act_q);
    wire div_wrap = (div_cnt_q >= div_max);
    wire sys_run = mode_clks[1];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 6'h00;
            div_act_q <= 3'b000;
            src_act_q <= 1'b1;
            sysclk_en <= 1'b0;
        end else if (clk_en) begin
            if (div_wrap || src_act_q) begin
                div_cnt_q <= 6'h00;
                div_act_q <= div_sel_q; // RULE19
                src_act_q <= src_sel_q; // RULE19
            end else begin
                div_cnt_q <= div_cnt_q + 6'h01; // RULE1
            end
            // RULE2 RULE4 RULE7 RULE9 RULE10
            sysclk_en <= sys_run && hrdy_q && (src_act_q || div_wrap);
        end
    end

    // Low-speed derived enables and mode outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_run <= 1'b0;
            sub_clk_en <= 1'b0;
            wdt_clk_en <= 1'b0;
            tbc_clk_en <= 1'b0;
            hold_state <= 1'b0;
        end else if (clk_en) begin
            cpu_run <= mode_clks[2] && hrdy_q; // RULE4 RULE6
            sub_clk_en <= low_rc_tick; // RULE5
            wdt_clk_en <= low_rc_tick && (wdt_enable || lvd_enable); // RULE8
            tbc_clk_en <= low_rc_tick && mode_clks[0]; // RULE5 RULE7
            hold_state <= (mode_q != `SCPM_M_NORMAL); // RULE12
        end
    end

endmodule

/* verif/scpm_top_checker.sv */
/*
 Port-level assertions for the clock and power-mode controller.
 Assumes it is bound to scpm_top and sees only its ports.
*/
`timescale 1ns/1ps

module scpm_top_checker (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Slow clock and outputs
    input wire low_rc_tick,
    input wire wdt_enable,
    input wire lvd_enable,
    input wire cpu_run,
    input wire sub_clk_en,
    input wire wdt_clk_en,
    input wire tbc_clk_en,
    input wire wdt_clear,
    input wire hold_state
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_sub; clk_en && low_rc_tick |=> sub_clk_en; endproperty
    a_sub: assert property (p_sub) else $error("substitute clock missed a tick");
    property p_tbc; tbc_clk_en |-> $past(low_rc_tick); endproperty
    a_tbc: assert property (p_tbc) else $error("time base pulse without tick");
    property p_wdt; clk_en && low_rc_tick && (wdt_enable || lvd_enable) |=> wdt_clk_en; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog clock missed a tick");
    property p_ready; clk_en && psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access phase");
    property p_idle; !psel |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("ready without select");
    property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
    a_err: assert property (p_err) else $error("error response malformed");
    property p_cpu; hold_state |-> !cpu_run; endproperty
    a_cpu: assert property (p_cpu) else $error("cpu runs in low power");
    property p_clear; wdt_clear |=> !wdt_clear; endproperty
    a_clear: assert property (p_clear) else $error("watchdog clear not a pulse");
    property p_entry; $rose(hold_state) |-> $past(wdt_clear); endproperty
    a_entry: assert property (p_entry) else $error("low-power entry without watchdog clear");

    c_halt: cover property ($rose(hold_state));
    c_err: cover property (pslverr);
    c_clear: cover property (wdt_clear);
endmodule

bind scpm_top scpm_top_checker u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .prdata, .pready,
    .pslverr, .low_rc_tick, .wdt_enable, .lvd_enable, .cpu_run, .sub_clk_en, .wdt_clk_en,
    .tbc_clk_en, .wdt_clear, .hold_state);

/* verif/tb_top.sv */
/*
 Self-checking bench for the clock and power-mode controller.
 Assumes pclk stands for the fast RC clock; slow ticks come every 4 cycles.
*/
`timescale 1ns/1ps
`include "scpm_defines.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; $display("Error %0t: got %h want %h", $time, a, e); end end

module tb_top;
    logic pclk = 0;
    logic presetn = 0;
    logic clk_en = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic low_rc_tick = 0;
    logic wdt_enable = 1;
    logic lvd_enable = 0;
    logic wdt_timeout = 0;
    wire [31:0] prdata;
    wire pready, pslverr, sysclk_en, cpu_run, sub_clk_en, wdt_clk_en, tbc_clk_en, wdt_clear, hold_state;
    int fail_count = 0;
    int checked = 0;
    int ticks = 0;
    logic [31:0] rdata;
    logic err;

    scpm_top u_scpm_top (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .low_rc_tick, .wdt_enable, .lvd_enable, .wdt_timeout, .sysclk_en, .cpu_run,
        .sub_clk_en, .wdt_clk_en, .tbc_clk_en, .wdt_clear, .hold_state);

    initial forever #4 pclk = ~pclk;

    always @(posedge pclk) begin
        ticks <= (ticks + 1) % 4;
        low_rc_tick <= (ticks == 3);
    end

    task print_verdict;
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
        if (n == 16) begin
            fail_count++;
            print_verdict;
        end
    endtask

    task rd(input logic [11:0] a, input logic [7:0] e);
        apb(0, a, 32'h0000_0000);
        `CHK(rdata[7:0], e)
    endtask

    // Any 128-cycle window holds exactly 128/N pulses of a period-N enable
    task cnt(output int s, output int t);
        s = 0;
        t = 0;
        repeat (128) begin
            @(posedge pclk);
            s += (sysclk_en === 1'b1);
            t += (tbc_clk_en === 1'b1);
        end
    endtask

    task t_reset;
        rd(`SCPM_OFS_MODE, 8'h03);
        rd(`SCPM_OFS_CTRL, 8'h00);
        repeat (140) @(posedge pclk);
        rd(`SCPM_OFS_MODE, 8'h0F);
    endtask

    task t_regs;
        apb(1, `SCPM_OFS_MODE, 32'h0000_00FF);
        rd(`SCPM_OFS_MODE, 8'hEF);
        apb(1, `SCPM_OFS_CTRL, 32'h0000_00FF);
        rd(`SCPM_OFS_CTRL, 8'h87);
        apb(0, 12'h010, 32'h0000_0000);
        `CHK({err, rdata}, {1'b1, 32'h0000_0000})
        apb(1, `SCPM_OFS_CTRL, 32'h0000_0000);
    endtask

    task t_div;
        int s, t;
        for (int c = 2; c < 8; c++) begin
            apb(1, `SCPM_OFS_MODE, c << 5);
            repeat (70) @(posedge pclk);
            cnt(s, t);
            `CHK(s, 2 << (c - 2))
        end
        apb(1, `SCPM_OFS_MODE, 32'h0000_0001);
        repeat (70) @(posedge pclk);
        cnt(s, t);
        `CHK(s, 128)
        `CHK(t, 32)
    endtask

    task t_modes;
        int s, t;
        for (int m = 1; m < 4; m++) begin
            apb(1, `SCPM_OFS_MODE, (m > 1) ? 32'h0000_0003 : 32'h0000_0001);
            apb(1, `SCPM_OFS_CTRL, (m == 3) ? 32'h0000_0080 : 32'h0000_0000);
            wdt_timeout <= 1;
            @(posedge pclk);
            wdt_timeout <= 0;
            rd(`SCPM_OFS_STAT, 8'h02);
            apb(1, `SCPM_OFS_CMD, 32'h0000_0001);
            rd(`SCPM_OFS_STAT, {2'b00, m[1:0], 4'b0001});
            cnt(s, t);
            `CHK({cpu_run, hold_state}, 2'b01)
            `CHK(s, (m == 3) ? 128 : 0)
            `CHK(t, (m == 1) ? 0 : 32)
            apb(1, `SCPM_OFS_CMD, 32'h0000_0004);
            apb(1, `SCPM_OFS_CMD, 32'h0000_0002);
            rd(`SCPM_OFS_STAT, 8'h00);
        end
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_regs;
        t_div;
        t_modes;
        print_verdict;
    end
endmodule
